// ### design/hss_pkg.sv
// Package of constants and carrier types for the hiccup soft-start sequencer
package hss_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int  CLK_MHZ           = 250;
    localparam int  HICCUP_MS         = 5;
    localparam int  HICCUP_CYCLES     = HICCUP_MS * 1000 * CLK_MHZ;
    localparam int  SS_TOTAL_US       = 1280;
    localparam int  SS_STEPS          = 128;
    localparam int  SS_STEP_CYCLES    = (SS_TOTAL_US * CLK_MHZ + SS_STEPS - 1) / SS_STEPS;
    localparam int  CAL_CYCLES        = 512;
    localparam int  PG_DEGLITCH_US    = 20;
    localparam int  PG_DEGLITCH_CYCLES = PG_DEGLITCH_US * CLK_MHZ;
    localparam int  OC_WINDOW         = 32;
    localparam int  OC_LIMIT          = 5;

    // ****************************************
    // Levels and codes
    // ****************************************
    localparam logic [7:0] SS_START      = 8'h00;
    localparam logic [7:0] SS_FULL       = 8'h80;
    localparam logic [3:0] LIMIT_FIXED   = 4'h5;   // Fixed 5 uA limit reference code
    localparam logic [3:0] LIMIT_TRACKED = 4'h0;   // Temperature-tracked reference code

    // Comparator inputs grouped together
    typedef struct packed {
        logic enableAbove;    // undervoltage_enable_input above 1.15 V rising threshold
        logic overCurrent;    // Current-limit comparator event
        logic ssBelowFb;      // Soft-start/track level below feedback_node
        logic ssAboveRef;     // Soft-start/track level at or above 0.6 V reference
        logic ssAbovePgHi;    // Soft-start/track level above 91 % of reference
        logic ssBelowPgLo;    // Soft-start/track level below 87 % of reference
        logic ssCapPresent;   // External capacitor or source sensed on soft-start pin
        logic diodeShorted;   // Remote diode pins shorted together
    } hss_cmp_t;

    // Gate-drive permissions
    typedef struct packed {
        logic highSide;       // high_side_gate_drive permission
        logic lowSide;        // low_side_gate_drive permission
    } hss_gate_t;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_CAL    = 3'b001,
        ST_WAITFB = 3'b010,
        ST_RUN    = 3'b011,
        ST_HICCUP = 3'b100
    } hss_state_t;

endpackage

// ### design/hss_sequencer.sv
// Hiccup, soft-start, tracking and power-good sequencing for a buck controller
`timescale 1ns/100ps
// Functional notes
// RULE1 - Five overcurrent events within 32 cycles stop switching for a 5 ms hiccup.
// RULE2 - During hiccup the low side never conducts, so no negative inductor current.
// RULE3 - After the hiccup interval the normal startup sequence and soft-start run again.
// RULE4 - Each current-limit event short of a trip turns high side off and low side on from the next clock edge.
// RULE5 - Soft-start begins only after the enable input crosses its rising threshold.
// RULE6 - Without a capacitor an internal 128-step ramp lasting at least 1.28 ms runs.
// RULE7 - Power-good asserts when soft-start level rises above 91 % of reference.
// RULE8 - Power-good deasserts when soft-start level falls below 87 % of reference.
// RULE9 - An externally driven track pin still leaves the internal digital ramp active.
// RULE10 - Track level sets regulation until it reaches the reference, then reference rules.
// RULE11 - Shorted diode pins disable compensation and select a fixed 5 uA limit reference.
// RULE12 - With a diode present the limit reference follows sensed inductor temperature.
// RULE13 - After enable a 512-cycle calibration wait precedes release of the track pin.
// RULE14 - The track pin is held to ground before switching and on every fault restart.
// RULE15 - Both gates stay low while the track level is below the feedback level.
// RULE16 - Power-good passes a 20 us deglitch filter.
// RULE17 - Overcurrent events age out exactly 32 cycles after being registered.
// RULE18 - Entering hiccup clears event history and restarts the soft-start step count.
module hss_sequencer
    import hss_pkg::*;
#(
    parameter int HICCUP_LEN   = HICCUP_CYCLES,
    parameter int PG_FILT_LEN  = PG_DEGLITCH_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire hss_cmp_t   cmp,
    output hss_gate_t       gate,
    output logic            ssPullDown,
    output logic [7:0]      ssLevel,
    output logic            useReference,
    output logic [3:0]      limitRefSelect,
    output logic            tempCompEnable,
    output logic            powerOkFlag,
    output logic            hiccupActive
);

    // ****************************************
    // State and counters
    // ****************************************
    hss_state_t   state;
    hss_state_t   next_state;
    logic [31:0]  timer;
    logic [31:0]  next_timer;
    logic [OC_WINDOW-1:0] ocHistory;
    logic [7:0]   ssStep;
    logic [31:0]  stepTimer;
    logic         pgRaw;
    logic         pgFiltTarget;
    logic [31:0]  pgTimer;

    // Count of events in the sliding window including this cycle
    logic [5:0]   ocCount;
    always_comb begin
        ocCount = {5'b0_0000, cmp.overCurrent};
        for (int i = 0; i < OC_WINDOW - 1; i++) begin
            ocCount = ocCount + {5'b0_0000, ocHistory[i]};
        end
    end

    wire logic ocTrip      = (state == ST_RUN || state == ST_WAITFB)
                             && (ocCount >= 6'(OC_LIMIT));          // [RULE1]
    wire logic hiccupDone  = (state == ST_HICCUP) && (timer == 32'(HICCUP_LEN - 1));
    wire logic calDone     = (state == ST_CAL) && (timer == 32'(CAL_CYCLES - 1));
    wire logic stepTick    = (stepTimer == 32'(SS_STEP_CYCLES - 1));
    wire logic rampActive  = (state == ST_WAITFB || state == ST_RUN) && (ssStep != SS_FULL);
    wire logic switching   = (state == ST_RUN) && !ocTrip;

    // ****************************************
    // Sequencer next-state decode
    // ****************************************
    always_comb begin
        next_state = state;
        next_timer = timer + 32'd1;
        case (state)
            ST_OFF: begin
                next_timer = 32'd0;
                if (cmp.enableAbove) begin
                    next_state = ST_CAL;                              // [RULE5]
                end
            end
            ST_CAL: begin
                if (calDone) begin
                    next_state = ST_WAITFB;                           // [RULE13]
                    next_timer = 32'd0;
                end
            end
            ST_WAITFB: begin
                next_timer = 32'd0;
                if (ocTrip) begin
                    next_state = ST_HICCUP;
                end else if (!cmp.ssBelowFb) begin
                    next_state = ST_RUN;                              // [RULE15]
                end
            end
            ST_RUN: begin
                next_timer = 32'd0;
                if (ocTrip) begin
                    next_state = ST_HICCUP;                           // [RULE1]
                end
            end
            ST_HICCUP: begin
                if (hiccupDone) begin
                    next_state = ST_CAL;                              // [RULE3]
                    next_timer = 32'd0;
                end
            end
            default: begin
                next_state = ST_OFF;
                next_timer = 32'd0;
            end
        endcase
        if (!cmp.enableAbove) begin
            next_state = ST_OFF;
            next_timer = 32'd0;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ST_OFF;
            timer <= 32'd0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // ****************************************
    // Overcurrent sliding window
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset || ocTrip || state == ST_HICCUP) begin
            ocHistory <= '0;                                          // [RULE18]
        end else begin
            ocHistory <= {ocHistory[OC_WINDOW-2:0], cmp.overCurrent}; // [RULE17]
        end
    end

    // ****************************************
    // Internal digital soft-start ramp
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset || ocTrip || state == ST_OFF || state == ST_CAL || state == ST_HICCUP) begin
            ssStep    <= SS_START;                                    // [RULE18]
            stepTimer <= 32'd0;
        end else if (rampActive) begin
            stepTimer <= stepTick ? 32'd0 : stepTimer + 32'd1;        // [RULE6]
            if (stepTick) begin
                ssStep <= ssStep + 8'h01;                             // [RULE9]
            end
        end
    end

    // ****************************************
    // Power-good with hysteresis and deglitch
    // ****************************************
    wire logic pgAllowed = (state == ST_RUN) && !cmp.overCurrent;
    always_ff @(posedge clk) begin
        if (reset || !pgAllowed) begin
            pgRaw <= 1'b0;
        end else if (cmp.ssAbovePgHi) begin
            pgRaw <= 1'b1;                                            // [RULE7]
        end else if (cmp.ssBelowPgLo) begin
            pgRaw <= 1'b0;                                            // [RULE8]
        end
    end

    // Flag follows the raw level only after it has been stable for the filter time
    always_ff @(posedge clk) begin
        if (reset) begin
            pgFiltTarget <= 1'b0;
            pgTimer      <= 32'd0;
            powerOkFlag  <= 1'b0;
        end else if (pgRaw != pgFiltTarget) begin
            pgFiltTarget <= pgRaw;
            pgTimer      <= 32'd0;
        end else if (pgTimer == 32'(PG_FILT_LEN - 1)) begin
            powerOkFlag  <= pgFiltTarget;                             // [RULE16]
        end else begin
            pgTimer      <= pgTimer + 32'd1;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            gate           <= '0;
            ssPullDown     <= 1'b1;
            ssLevel        <= SS_START;
            useReference   <= 1'b0;
            limitRefSelect <= LIMIT_FIXED;
            tempCompEnable <= 1'b0;
            hiccupActive   <= 1'b0;
        end else begin
            // Gates: cycle-by-cycle limit forces low side, hiccup and prebias keep both low
            if (!switching || cmp.ssBelowFb) begin
                gate <= '0;                                           // [RULE2] [RULE15]
            end else if (cmp.overCurrent) begin
                gate <= '{highSide: 1'b0, lowSide: 1'b1};             // [RULE4]
            end else begin
                gate <= '{highSide: 1'b1, lowSide: 1'b1};
            end
            ssPullDown   <= (next_state == ST_OFF || next_state == ST_CAL
                             || next_state == ST_HICCUP);            // [RULE14]
            ssLevel      <= ssStep;
            useReference <= cmp.ssAboveRef;                           // [RULE10]
            limitRefSelect <= cmp.diodeShorted ? LIMIT_FIXED : LIMIT_TRACKED; // [RULE11]
            tempCompEnable <= !cmp.diodeShorted;                      // [RULE12]
            hiccupActive <= (next_state == ST_HICCUP);
        end
    end

endmodule

// ### tb/hss_checker_props.sv
// Port timing checker for the hiccup soft-start sequencer
`timescale 1ns/100ps
module hss_checker
    import hss_pkg::*;
#(
    parameter int HICCUP_LEN  = 100,
    parameter int PG_FILT_LEN = 10
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire hss_cmp_t   cmp,
    input wire hss_gate_t  gate,
    input wire logic       ssPullDown,
    input wire logic [7:0] ssLevel,
    input wire logic       useReference,
    input wire logic [3:0] limitRefSelect,
    input wire logic       tempCompEnable,
    input wire logic       powerOkFlag,
    input wire logic       hiccupActive
);
    logic [31:0] ocHist;
    int          enCnt;
    int          hicCnt;
    int          loCnt;
    int          okCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Event history and run-length counters
    always_ff @(posedge clk) begin
        if (reset) begin
            ocHist <= '0;
            enCnt  <= 0;
            hicCnt <= 0;
            loCnt  <= 0;
            okCnt  <= 0;
        end else begin
            ocHist <= {ocHist[30:0], cmp.overCurrent};
            enCnt  <= cmp.enableAbove ? enCnt + 1 : 0;
            hicCnt <= hiccupActive ? hicCnt + 1 : 0;
            loCnt  <= cmp.ssBelowPgLo ? loCnt + 1 : 0;
            okCnt  <= cmp.ssBelowPgLo ? 0 : okCnt + 1;
        end
    end
    property p_trip; $rose(hiccupActive) |-> $countones(ocHist) >= OC_LIMIT; endproperty
    a_trip: assert property (p_trip) else $error("hiccup without enough events");
    property p_len; $fell(hiccupActive) |-> hicCnt >= HICCUP_LEN - 1 && hicCnt <= HICCUP_LEN + 1;
    endproperty
    a_len: assert property (p_len) else $error("hiccup length wrong");
    property p_quiet; hiccupActive |-> gate == 2'b00; endproperty
    a_quiet: assert property (p_quiet) else $error("gate active in hiccup");
    property p_restart; $fell(hiccupActive) |-> ssPullDown && ssLevel == SS_START; endproperty
    a_restart: assert property (p_restart) else $error("restart not clean");
    property p_cut; cmp.overCurrent && gate.highSide |=> !gate.highSide; endproperty
    a_cut: assert property (p_cut) else $error("high side kept on");
    property p_off; !cmp.enableAbove [*3] |-> ssPullDown && gate == 2'b00; endproperty
    a_off: assert property (p_off) else $error("active while disabled");
    property p_cal; $fell(ssPullDown) |-> enCnt >= CAL_CYCLES; endproperty
    a_cal: assert property (p_cal) else $error("track pin released early");
    property p_limit; cmp.diodeShorted |=> limitRefSelect == LIMIT_FIXED && !tempCompEnable;
    endproperty
    a_limit: assert property (p_limit) else $error("fixed limit not chosen");
    property p_pg_lo; loCnt > PG_FILT_LEN + 3 |-> !powerOkFlag; endproperty
    a_pg_lo: assert property (p_pg_lo) else $error("power good stuck high");
    property p_pg_rise; $rose(powerOkFlag) |-> okCnt >= PG_FILT_LEN; endproperty
    a_pg_rise: assert property (p_pg_rise) else $error("power good not filtered");
    property p_prebias; gate != 2'b00 && $past(gate) == 2'b00 |-> !$past(cmp.ssBelowFb);
    endproperty
    a_prebias: assert property (p_prebias) else $error("switching below feedback");
    c_trip: cover property ($rose(hiccupActive));
    c_pg: cover property ($rose(powerOkFlag));
    c_cut: cover property (gate == 2'b01);
endmodule
bind hss_sequencer hss_checker #(.HICCUP_LEN(HICCUP_LEN), .PG_FILT_LEN(PG_FILT_LEN)) i_chk (
    .clk(clk), .reset(reset), .cmp(cmp), .gate(gate), .ssPullDown(ssPullDown),
    .ssLevel(ssLevel), .useReference(useReference), .limitRefSelect(limitRefSelect),
    .tempCompEnable(tempCompEnable), .powerOkFlag(powerOkFlag), .hiccupActive(hiccupActive));

// ### tb/hss_stage_model.sv
// Behavioural comparators around the soft-start/track pin
`timescale 1ns/100ps
module hss_stage_model
    import hss_pkg::*;
(
    input  wire logic       enable,
    input  wire logic       ocReq,
    input  wire logic       extOn,
    input  wire logic [7:0] extLevel,
    input  wire logic [7:0] fbLevel,
    input  wire logic       diode,
    input  wire logic       ssPullDown,
    input  wire logic [7:0] ssLevel,
    output hss_cmp_t        cmp
);
    logic [7:0] trk;
    // Pin level: pull-down wins, else external source or internal ramp
    assign trk = ssPullDown ? 8'h00 : (extOn ? extLevel : ssLevel);
    // Comparators against feedback, reference (128) and 91 % / 87 % points
    assign cmp = '{enableAbove: enable, overCurrent: ocReq, ssBelowFb: trk < fbLevel,
                   ssAboveRef: trk >= 8'h80, ssAbovePgHi: trk > 8'h74,
                   ssBelowPgLo: trk < 8'h70, ssCapPresent: extOn, diodeShorted: diode};
endmodule

// ### tb/testbench.sv
// Self-checking bench for the hiccup soft-start sequencer
`timescale 1ns/100ps
module testbench
    import hss_pkg::*;
;
    typedef struct {logic d; logic [7:0] lv; logic [3:0] lim; logic tc; logic ur;} hss_row_t;
    hss_row_t rows [4] = '{'{0, 8'h40, 4'h0, 1, 0}, '{1, 8'h7F, 4'h5, 0, 0},
                           '{0, 8'h80, 4'h0, 1, 1}, '{1, 8'hFF, 4'h5, 0, 1}};
    localparam int PF = 10;
    logic clk = 0, reset = 1, enable = 0, ocReq = 0, extOn = 0, diode = 0;
    logic [7:0] extLevel = 8'h00, fbLevel = 8'h30, ssLevel;
    logic [3:0] limitRefSelect;
    logic ssPullDown, useReference, tempCompEnable, powerOkFlag, hiccupActive;
    hss_cmp_t cmp;
    hss_gate_t gate;
    int failures = 0, n_tests = 0, k;
    always #2 clk = ~clk;
    hss_stage_model i_hss_stage_model (.enable(enable), .ocReq(ocReq), .extOn(extOn),
        .extLevel(extLevel), .fbLevel(fbLevel), .diode(diode), .ssPullDown(ssPullDown),
        .ssLevel(ssLevel), .cmp(cmp));
    hss_sequencer #(.HICCUP_LEN(100), .PG_FILT_LEN(PF)) i_hss_sequencer (.clk(clk),
        .reset(reset), .cmp(cmp), .gate(gate), .ssPullDown(ssPullDown), .ssLevel(ssLevel),
        .useReference(useReference), .limitRefSelect(limitRefSelect),
        .tempCompEnable(tempCompEnable), .powerOkFlag(powerOkFlag), .hiccupActive(hiccupActive));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic oc(input int hi, input int lo);
        @(posedge clk) ocReq <= 1;
        cyc(hi - 1);
        @(posedge clk) ocReq <= 0;
        cyc(lo - 1);
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog against a hung sequence
    initial begin
        #80000;
        failures++;
        report_and_stop;
    end
    // Main sequence
    initial begin
        cyc(8);
        reset <= 0;
        cyc(20);
        #1 check({gate, ssPullDown, powerOkFlag}, 8'h02, "idle outputs");
        @(posedge clk) enable <= 1;
        for (k = 0; ssPullDown !== 1'b0 && k < 600; k++) begin
            cyc(1);
            #1;
        end
        check(k >= 513 && k <= 516, 1, "calibration wait");
        cyc(2530);
        #1 check(gate, 8'h00, "prebias hold");
        check(ssLevel, 8'h01, "ramp step");
        @(posedge clk) fbLevel <= 8'h00;
        cyc(3);
        #1 check(gate, 8'h03, "switching start");
        @(posedge clk) extOn <= 1;
        foreach (rows[i]) begin
            @(posedge clk) diode <= rows[i].d;
            extLevel <= rows[i].lv;
            cyc(3);
            #1 check({rows[i].tc, limitRefSelect}, {rows[i].tc, rows[i].lim}, "limit");
            check(tempCompEnable, rows[i].tc, "compensation");
            check(useReference, rows[i].ur, "reference");
        end
        @(posedge clk) extLevel <= 8'h78;
        cyc(PF + 6);
        #1 check(powerOkFlag, 1, "pg rise");
        @(posedge clk) extLevel <= 8'h60;
        cyc(3);
        @(posedge clk) extLevel <= 8'h78;
        cyc(PF + 6);
        #1 check(powerOkFlag, 1, "pg glitch");
        @(posedge clk) extLevel <= 8'h71;
        cyc(PF + 6);
        #1 check(powerOkFlag, 1, "pg hysteresis");
        @(posedge clk) extLevel <= 8'h60;
        cyc(PF + 6);
        #1 check(powerOkFlag, 0, "pg fall");
        @(posedge clk) ocReq <= 1;
        @(posedge clk) ocReq <= 0;
        #1 check(gate, 8'h01, "limit event");
        cyc(40);
        oc(4, 28);
        oc(2, 3);
        #1 check(hiccupActive, 0, "events aged out");
        cyc(40);
        oc(5, 2);
        #1 check({hiccupActive, gate}, 8'h04, "hiccup entry");
        for (k = 1; hiccupActive === 1'b1 && k < 300; k++) begin
            cyc(1);
            #1;
        end
        check(k >= 99 && k <= 102, 1, "hiccup length");
        check(ssPullDown, 1, "restart pull-down");
        check(ssLevel, 8'h00, "restart ramp");
        for (k = 0; ssPullDown !== 1'b0 && k < 600; k++) begin
            cyc(1);
            #1;
        end
        check(k >= 510 && k <= 516, 1, "restart calibration");
        @(posedge clk) enable <= 0;
        cyc(3);
        #1 check({gate, ssPullDown}, 8'h01, "disable");
        report_and_stop;
    end
endmodule
